/* File: verilog/burst_sram_pkg.sv */
// shared constants for the four-word burst sram port
package burst_sram_pkg;
    localparam int BURST_LEN      = 4;
    localparam int BEAT_W         = 2;
    localparam int LAT_PLL_ON     = 2;
    localparam int LAT_PLL_OFF    = 1;
    localparam int DEF_WORD_W     = 18;
    localparam int DEF_ADDR_W     = 8;
    localparam int LINK_PERIOD_NS = 160;
    localparam int SYS_PERIOD_NS  = 5;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam int TXT_LAT_FIFO   = 8;

    typedef enum logic [1:0] {
        SLOT_READ  = 2'b00,
        SLOT_WRITE = 2'b01
    } slot_t;
endpackage : burst_sram_pkg

/* File: verilog/link_edge_if.sv */
// edge strobes of the sampled input clock pair, passed to the core
`timescale 1ns/100ps
`default_nettype none
interface link_edge_if;
    logic k_rise;
    logic kn_rise;
    modport src (output k_rise, output kn_rise);
    modport dst (input k_rise, input kn_rise);
endinterface : link_edge_if
`default_nettype wire

/* File: verilog/link_edge_detect.sv */
// synchronises the true and complement input clocks and finds their rising edges
`timescale 1ns/100ps
`default_nettype none
module link_edge_detect (
    // clock and reset
    input  wire logic    sys_clk_i,
    input  wire logic    rst_i,
    // raw input clocks
    input  wire logic    k_i,
    input  wire logic    kn_i,
    // edge strobes
    link_edge_if.src     edge_o
);
    logic [1:0] k_sync_q;
    logic [1:0] kn_sync_q;
    logic       k_last_q;
    logic       kn_last_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            k_sync_q  <= 2'h0;
            kn_sync_q <= 2'h0;
        end else begin
            k_sync_q  <= {k_sync_q[0], k_i};
            kn_sync_q <= {kn_sync_q[0], kn_i};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // start as if high; the synchronisers reset low, so a pin already high after reset still gives one edge
            k_last_q  <= 1'b1;
            kn_last_q <= 1'b1;
        end else begin
            k_last_q  <= k_sync_q[1];
            kn_last_q <= kn_sync_q[1];
        end
    end

    assign edge_o.k_rise  = k_sync_q[1] & ~k_last_q;
    assign edge_o.kn_rise = kn_sync_q[1] & ~kn_last_q;
endmodule : link_edge_detect
`default_nettype wire

/* File: verilog/burst_sram_port.sv */
// four-word burst ddr sram core with separate read and write ports
`timescale 1ns/100ps
`default_nettype none
module burst_sram_port
    import burst_sram_pkg::*;
#(
    parameter int WORD_W = DEF_WORD_W,
    parameter int ADDR_W = DEF_ADDR_W
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // input clock pair from the controller
    input  wire logic              k_i,
    input  wire logic              kn_i,
    // address, selects and mode
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              read_sel_n_i,
    input  wire logic              write_sel_n_i,
    input  wire logic              pll_disable_pin_i,
    // write data port
    input  wire logic [WORD_W-1:0] wdata_i,
    // read data port and echo clocks
    output logic      [WORD_W-1:0] rdata_o,
    output logic                   read_valid_flag_o,
    output logic                   echo_clock_true_o,
    output logic                   echo_clock_complement_o
);
    if (WORD_W != 18 && WORD_W != 36) begin : g_bad_word
        $error("word width must be 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr
        $error("address width out of range");
    end

    localparam int DEPTH = (1 << ADDR_W) * BURST_LEN;

    // input synchronisers for address, selects, data and mode
    logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    logic [WORD_W-1:0] wdata_s1_q, wdata_s2_q;
    logic [2:0]        ctl_s1_q, ctl_s2_q;
    link_edge_if       edge_bus ();

    link_edge_detect u_edge (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .k_i       (k_i),
        .kn_i      (kn_i),
        .edge_o    (edge_bus.src)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            addr_s1_q  <= '0;
            addr_s2_q  <= '0;
            wdata_s1_q <= '0;
            wdata_s2_q <= '0;
            ctl_s1_q   <= 3'h3;
            ctl_s2_q   <= 3'h3;
        end else begin
            addr_s1_q  <= addr_i;
            addr_s2_q  <= addr_s1_q;
            wdata_s1_q <= wdata_i;
            wdata_s2_q <= wdata_s1_q;
            ctl_s1_q   <= {pll_disable_pin_i, write_sel_n_i, read_sel_n_i};
            ctl_s2_q   <= ctl_s1_q;
        end
    end

    wire logic k_edge  = edge_bus.k_rise;
    wire logic kn_edge = edge_bus.kn_rise;
    wire logic any_edge = k_edge | kn_edge;

    // alternating address slot on the true edge
    slot_t slot_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            slot_q <= SLOT_READ;
        end else if (k_edge) begin
            slot_q <= (slot_q == SLOT_READ) ? SLOT_WRITE : SLOT_READ;
        end
    end

    wire logic rd_start = k_edge && slot_q == SLOT_READ && !ctl_s2_q[0];
    wire logic wr_start = k_edge && slot_q == SLOT_WRITE && !ctl_s2_q[1];

    // memory array
    logic [WORD_W-1:0] mem_q [DEPTH];

    // write burst capture, one word per edge
    logic [ADDR_W-1:0] wr_addr_q;
    logic [BEAT_W:0]   wr_left_q;
    logic [BEAT_W-1:0] wr_beat_q;
    logic              wr_pend_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_addr_q <= '0;
            wr_left_q <= '0;
            wr_beat_q <= '0;
        end else if (wr_start) begin
            wr_addr_q <= addr_s2_q;
            wr_left_q <= (BEAT_W+1)'(BURST_LEN);
            wr_beat_q <= '0;
        end else if (any_edge && wr_left_q != '0) begin
            wr_left_q <= wr_left_q - 1'b1;
            wr_beat_q <= wr_beat_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (any_edge && wr_left_q != '0 && !wr_start) begin
            mem_q[{wr_addr_q, wr_beat_q}] <= wdata_s2_q;
        end
    end

    assign wr_pend_q = wr_left_q != '0;

    // read burst scheduling with latency in edges
    logic [ADDR_W-1:0] rd_addr_q;
    logic [3:0]        rd_wait_q;
    logic [BEAT_W:0]   rd_left_q;
    logic [BEAT_W-1:0] rd_beat_q;
    wire  logic [3:0]  lat_edges = ctl_s2_q[2] ? 4'(2 * LAT_PLL_ON - 1)
                                                : 4'(2 * LAT_PLL_OFF - 1);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_addr_q <= '0;
            rd_wait_q <= '0;
            rd_left_q <= '0;
            rd_beat_q <= '0;
        end else if (rd_start) begin
            rd_addr_q <= addr_s2_q;
            rd_wait_q <= lat_edges;
            rd_left_q <= (BEAT_W+1)'(BURST_LEN);
            rd_beat_q <= '0;
        end else if (any_edge) begin
            if (rd_wait_q != '0) begin
                rd_wait_q <= rd_wait_q - 1'b1;
            end else if (rd_left_q != '0) begin
                rd_left_q <= rd_left_q - 1'b1;
                rd_beat_q <= rd_beat_q + 1'b1;
            end
        end
    end

    // coherent read word: bypass the word being written this edge
    wire logic [ADDR_W+BEAT_W-1:0] rd_loc = {rd_addr_q, rd_beat_q};
    wire logic [ADDR_W+BEAT_W-1:0] wr_loc = {wr_addr_q, wr_beat_q};
    wire logic rd_fire = any_edge && rd_wait_q == '0 && rd_left_q != '0 && !rd_start;
    wire logic [WORD_W-1:0] rd_word = (wr_pend_q && rd_loc == wr_loc)
                                      ? wdata_s2_q : mem_q[rd_loc];

    // output registers on input clock edges
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o           <= '0;
            read_valid_flag_o <= 1'b0;
        end else if (any_edge) begin
            rdata_o           <= rd_fire ? rd_word : rdata_o;
            read_valid_flag_o <= rd_fire;
        end
    end

    // echo clocks follow the sampled input clock pair
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            echo_clock_true_o       <= 1'b0;
            echo_clock_complement_o <= 1'b1;
        end else if (any_edge) begin
            echo_clock_true_o       <= k_edge;
            echo_clock_complement_o <= ~k_edge;
        end
    end

    // assertions
    logic [2:0] fire_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || rd_start) fire_cnt_q <= '0;
        else if (rd_fire && fire_cnt_q != 3'h7) fire_cnt_q <= fire_cnt_q + 1'b1;
    end

    // last stored word and its location, for the coherency check
    logic [ADDR_W+BEAT_W-1:0] last_loc_q;
    logic [WORD_W-1:0]        last_word_q;
    logic                     last_ok_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            last_loc_q  <= '0;
            last_word_q <= '0;
            last_ok_q   <= 1'b0;
        end else if (any_edge && wr_pend_q && !wr_start) begin
            last_loc_q  <= wr_loc;
            last_word_q <= wdata_s2_q;
            last_ok_q   <= 1'b1;
        end
    end

    sequence burst_start_s;
        rd_start;
    endsequence

    valid_on_fire_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rd_fire |=> read_valid_flag_o)
        else $error("read valid flag missing after read beat");
    valid_drop_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (any_edge && !rd_fire) |=> !read_valid_flag_o)
        else $error("read valid flag high without read beat");
    burst_four_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fire_cnt_q <= 3'(BURST_LEN))
        else $error("read burst exceeded four words");
    slot_alt_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        k_edge |=> slot_q != $past(slot_q))
        else $error("address slot did not alternate");
    sel_gate_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ctl_s2_q[0] |-> !rd_start)
        else $error("read started while deselected");
    lat_load_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        burst_start_s |=> rd_wait_q == (ctl_s2_q[2] ? 4'h3 : 4'h1) || $changed(ctl_s2_q[2]))
        else $error("read latency not loaded");
    coherent_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_fire && wr_pend_q && rd_loc == wr_loc) |=> rdata_o == $past(wdata_s2_q))
        else $error("read missed pending write data");
    newest_word_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_fire && last_ok_q && rd_loc == last_loc_q && !(wr_pend_q && rd_loc == wr_loc))
        |=> rdata_o == $past(last_word_q))
        else $error("read missed most recent stored word");
    echo_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        echo_clock_true_o != echo_clock_complement_o)
        else $error("echo clocks not complementary");
    wr_self_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_start |=> wr_left_q == 3'(BURST_LEN))
        else $error("write burst not armed");
endmodule : burst_sram_port
`default_nettype wire

/* File: testbench/sram_host_model.sv */
// host controller model: input clocks, address, selects, write data
`timescale 1ns/100ps
`default_nettype none
module sram_host_model
    import burst_sram_pkg::*;
#(
    parameter int WORD_W = DEF_WORD_W,
    parameter int ADDR_W = DEF_ADDR_W
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // link side
    output logic                   k_o,
    output logic                   kn_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   read_sel_n_o,
    output logic                   write_sel_n_o,
    output logic      [WORD_W-1:0] wdata_o
);
    logic [ADDR_W:0]   rd_q[$];
    logic [ADDR_W:0]   wr_q[$];
    logic [WORD_W-1:0] wq[$];
    logic [WORD_W-1:0] dq[$];
    logic              wr_next = 1'b0;
    logic [ADDR_W:0]   ent;

    // free-running clock pair, phase unrelated to the system clock
    initial begin
        k_o = 1'b0;
        kn_o = 1'b1;
        addr_o = '0;
        read_sel_n_o = 1'b1;
        write_sel_n_o = 1'b1;
        wdata_o = '0;
        #37.3;
        forever begin
            #(LINK_PERIOD_NS / 2);
            k_o = ~k_o;
            kn_o = ~kn_o;
        end
    end

    // set up the values for the coming edge
    always @(k_o) begin
        if (k_o) begin
            wr_next = rst_i ? 1'b0 : ~wr_next;
        end
        @(posedge sys_clk_i);
        wdata_o <= (dq.size() != 0) ? dq.pop_front() : ~wdata_o;
        if (k_o) begin
            read_sel_n_o <= 1'b1;
            write_sel_n_o <= 1'b1;
            addr_o <= ~addr_o;
        end else begin
            ent = '0;
            if (wr_next && wr_q.size() != 0) ent = wr_q.pop_front();
            if (!wr_next && rd_q.size() != 0) ent = rd_q.pop_front();
            read_sel_n_o <= ~(ent[ADDR_W] & ~wr_next);
            write_sel_n_o <= ~(ent[ADDR_W] & wr_next);
            addr_o <= ent[ADDR_W] ? ent[ADDR_W-1:0] : ~addr_o;
            if (ent[ADDR_W] && wr_next) begin
                repeat (BURST_LEN) dq.push_back(wq.pop_front());
            end
        end
    end

    // queue one read and one write slot
    task automatic post(input logic rs, input logic [ADDR_W-1:0] ra, input logic ws,
                        input logic [ADDR_W-1:0] wa, input logic [WORD_W-1:0] b);
        rd_q.push_back({rs, ra});
        wr_q.push_back({ws, wa});
        for (int i = 0; i < BURST_LEN; i++) if (ws) wq.push_back(b + WORD_W'(i));
    endtask : post
endmodule : sram_host_model
`default_nettype wire

/* File: testbench/test_burst_sram_port.sv */
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`default_nettype none
module test_burst_sram_port;
    import burst_sram_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  pll = 1'b1;
    logic                  k;
    logic                  kn;
    logic [DEF_ADDR_W-1:0] addr;
    logic                  rsel_n;
    logic                  wsel_n;
    logic [DEF_WORD_W-1:0] wd;
    logic [DEF_WORD_W-1:0] rd;
    logic                  vld;
    logic                  ect;
    logic                  ecc;
    int                    num_errors = 0;
    int                    checked = 0;
    int                    kcnt = 0;

    always #(SYS_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
    always @(posedge k) kcnt <= rst ? 0 : kcnt + 1;

    sram_host_model sram_host_model_i (.sys_clk_i(sys_clk), .rst_i(rst), .k_o(k), .kn_o(kn),
        .addr_o(addr), .read_sel_n_o(rsel_n), .write_sel_n_o(wsel_n), .wdata_o(wd));

    burst_sram_port burst_sram_port_i (.sys_clk_i(sys_clk), .rst_i(rst), .k_i(k), .kn_i(kn),
        .addr_i(addr), .read_sel_n_i(rsel_n), .write_sel_n_i(wsel_n),
        .pll_disable_pin_i(pll), .wdata_i(wd), .rdata_o(rd), .read_valid_flag_o(vld),
        .echo_clock_true_o(ect), .echo_clock_complement_o(ecc));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // wait for a pair that starts on a read slot, queue it, return at its read edge
    task automatic issue(input logic rs, input logic [7:0] ra, input logic ws,
                         input logic [7:0] wa, input logic [17:0] b);
        do begin
            @(posedge k);
            #1;
        end while (kcnt[0]);
        sram_host_model_i.post(rs, ra, ws, wa, b);
        @(posedge k);
    endtask : issue

    // sample each edge interval from the read edge on
    task automatic burst(input int lat, input logic [17:0] b, input logic on);
        int   first;
        logic ev;
        first = 2 * lat;
        for (int e = 0; e <= first + BURST_LEN; e++) begin
            if (e > 0) @(posedge k or posedge kn);
            #(LINK_PERIOD_NS / 4);
            ev = on && e >= first && e < first + BURST_LEN;
            chk("echo_true", k, ect);
            chk("echo_comp", kn, ecc);
            chk("valid", ev, vld);
            if (ev) chk("rdata", b + 18'(e - first), rd);
        end
    endtask : burst

    task automatic write_then_read();
        issue(1'b0, 8'h00, 1'b1, 8'h12, 18'h00a10);
        issue(1'b1, 8'h12, 1'b0, 8'h00, 18'h0);
        burst(LAT_PLL_ON, 18'h00a10, 1'b1);
    endtask : write_then_read

    task automatic short_latency();
        @(posedge sys_clk);
        pll <= 1'b0;
        issue(1'b1, 8'h12, 1'b0, 8'h00, 18'h0);
        burst(LAT_PLL_OFF, 18'h00a10, 1'b1);
        @(posedge sys_clk);
        pll <= 1'b1;
    endtask : short_latency

    task automatic concurrent();
        issue(1'b1, 8'h12, 1'b1, 8'h56, 18'h2bcd0);
        burst(LAT_PLL_ON, 18'h00a10, 1'b1);
        issue(1'b1, 8'h56, 1'b0, 8'h00, 18'h0);
        burst(LAT_PLL_ON, 18'h2bcd0, 1'b1);
    endtask : concurrent

    task automatic deselected();
        issue(1'b0, 8'h12, 1'b0, 8'h12, 18'h3ff00);
        burst(LAT_PLL_ON, 18'h0, 1'b0);
        issue(1'b1, 8'h12, 1'b0, 8'h00, 18'h0);
        burst(LAT_PLL_ON, 18'h00a10, 1'b1);
    endtask : deselected

    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #20000;
        num_errors++;
        $display("[ERR] run time expected done seen hang");
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk("valid_rst", 1'b0, vld);
        chk("echo_comp_rst", 1'b1, ecc);
        @(posedge sys_clk);
        rst <= 1'b0;
        write_then_read();
        short_latency();
        concurrent();
        deselected();
        tally_and_finish();
    end
endmodule : test_burst_sram_port
`default_nettype wire
